/* logic/afe_ctrl_pkg.sv */
// constants and carrier types for the front-end control register bank
// assumes a single 200 MHz clock; control words are decoded outside
package afe_ctrl_pkg;
	localparam int N_CHAN = 6;
	localparam int N_REGS = 8;
	// register indices, as carried in the control word register field
	localparam logic [2:0] MODE_CONTROL_IDX = 3'h0;
	localparam logic [2:0] CLOCK_DIVIDER_IDX = 3'h1;
	localparam logic [2:0] POWER_REFERENCE_IDX = 3'h2;
	localparam logic [2:0] GAIN_PAIR1_IDX = 3'h3;
	localparam logic [2:0] INPUT_CONFIG_IDX = 3'h6;
	localparam logic [2:0] POLARITY_CONFIG_IDX = 3'h7;
	localparam logic [7:0] REG_RESET_VAL = 8'h00;
	// mode register fields
	localparam int DATA_PROGRAM_BIT = 0;
	localparam int MIXED_MODE_BIT = 1;
	localparam int LOOPBACK_BIT = 3;
	localparam int CASCADE_LSB = 4;
	localparam int SOFT_RESET_BIT = 7;
	// clock register fields
	localparam int DECIM_LSB = 0;
	localparam int SCLK_DIV_LSB = 2;
	localparam int MDIV_LSB = 4;
	localparam int ECHO_BIT = 7;
	// power register fields
	localparam int GLOBAL_PU_BIT = 0;
	localparam int REF_POWER_BIT = 5;
	localparam int REF_OUT_BIT = 6;
	localparam int HIGH_SUPPLY_BIT = 7;
	// channel pair register fields
	localparam int ODD_GAIN_LSB = 0;
	localparam int ODD_POWER_BIT = 3;
	localparam int EVEN_GAIN_LSB = 4;
	localparam int EVEN_POWER_BIT = 7;
	// input and polarity register fields
	localparam int CHAN_SEL_LSB = 0;
	localparam int MOD_RESET_BIT = 6;
	localparam int SINGLE_ENDED_BIT = 7;
	localparam int TEST_MODE_BIT = 6;
	localparam int FLIP_ENABLE_BIT = 7;
	// reset lasts this many divided-clock cycles
	localparam logic [2:0] RESET_DIVIDED_MASTER_CLOCK_CYCLES = 3'h4;
	typedef enum logic [2:0] {
		MODE_PROGRAM = 3'b001,
		MODE_DATA = 3'b010,
		MODE_MIXED = 3'b100
	} op_mode_t;
	typedef enum logic [1:0] {
		ST_RESET = 2'b01,
		ST_RUN = 2'b10
	} bank_state_t;
	typedef struct packed {
		logic [2:0] gain;
		logic powered;
		logic single_ended;
		logic mod_reset;
		logic inverted;
	} chan_ctrl_t;
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] data;
	} reg_write_t;
endpackage : afe_ctrl_pkg

/* logic/afe_control_registers_clock_dividers.sv */
// control register bank of a six-channel sampling front end, with the
// master-clock and serial-clock dividers and the sample-rate strobe.
// assumes an outside control-word decoder presents one register write
// per reg_wr pulse; every rate is an enable pulse on ref_clk.
// How it works
// - mixed off: program/data bit picks mode
// - mixed bit on forces mixed mode
// - soft reset bit starts whole-device reset
// - echo bit sends control words back out
// - decimation field picks converter sample rate
// - global power-up overrides channel power bits
// - reference powered by bit or any channel
// - reference-output bit drives pin enable
// - high-supply bit selects 5 V mode
// - three-bit gain per channel, pair packed
// - bits 3 and 7 power pair channels
// - modulator reset on selected channels only
// - single-ended on selected channels when enabled
// - unselected channel differential, modulator running
// - invert enable flips selected channels
// - unselected or disabled channels never inverted
// - master divider codes 1..4, others undivided
// - master divider resets to divide-by-one
// - serial clock divides by 1, 2, 4, 8
// - serial clock slowest after reset
// - serial codes 00..11 give 8,4,2,1
// - decimation codes give 2048,1024,512,256
// - any reset zeroes registers over four cycles
`timescale 1ns/1ps
`default_nettype none
module afe_control_registers_clock_dividers
	import afe_ctrl_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// register writes from the control-word decoder
	input wire logic reg_wr,
	input wire reg_write_t reg_wr_req,
	// register read-back select
	input wire logic [2:0] reg_rd_addr,
	output logic [7:0] reg_rd_data,
	// operating mode and serial port controls
	output op_mode_t op_mode,
	output logic [2:0] cascade_count_field,
	output logic control_echo,
	output logic port_loopback,
	output logic test_mode_bit,
	output logic reset_busy,
	// clock enables
	output logic divided_master_clock,
	output logic serial_clock_en,
	output logic sample_en,
	// analog controls
	output chan_ctrl_t [N_CHAN-1:0] chan_ctrl,
	output logic reference_power,
	output logic reference_output_pin,
	output logic high_supply_mode
);
	// whole module state, registered as one word
	typedef struct packed {
		bank_state_t st;
		logic [N_REGS-1:0][7:0] regs;
		logic [2:0] mdiv_cnt; // ref_clk cycles inside one divided period
		logic [2:0] sdiv_cnt; // divided cycles inside one serial period
		logic [10:0] dec_cnt; // divided cycles inside one sample period
		logic [2:0] rst_cnt; // divided cycles left in reset
		logic [7:0] rd_data;
		op_mode_t mode;
		logic divided_master_clock_en;
		logic sclk_en;
		logic smp_en;
		chan_ctrl_t [N_CHAN-1:0] chan;
		logic ref_pwr;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	// master divider ratio minus one; spare codes run undivided
	function automatic logic [2:0] mdiv_last(input logic [2:0] code);
		case (code)
			3'h1: mdiv_last = 3'h1;
			3'h2: mdiv_last = 3'h2;
			3'h3: mdiv_last = 3'h3;
			3'h4: mdiv_last = 3'h4;
			default: mdiv_last = 3'h0;
		endcase
	endfunction : mdiv_last

	// serial divider mask: period is mask + 1 divided cycles
	function automatic logic [2:0] sdiv_mask(input logic [1:0] code);
		case (code)
			2'h0: sdiv_mask = 3'h7;
			2'h1: sdiv_mask = 3'h3;
			2'h2: sdiv_mask = 3'h1;
			default: sdiv_mask = 3'h0;
		endcase
	endfunction : sdiv_mask

	// decimation mask: sample period is mask + 1 divided cycles
	function automatic logic [10:0] dec_mask(input logic [1:0] code);
		case (code)
			2'h0: dec_mask = 11'h7ff; // default, slowest
			2'h1: dec_mask = 11'h3ff;
			2'h2: dec_mask = 11'h1ff;
			default: dec_mask = 11'h0ff;
		endcase
	endfunction : dec_mask

	// per-channel decode from the pair registers, done once per channel
	logic [N_CHAN-1:0][2:0] gain_w;
	logic [N_CHAN-1:0] own_pwr_w;
	genvar g;
	generate
		for (g = 0; g < N_CHAN; g = g + 1) begin : g_chan
			localparam int PAIR = g / 2;
			if (g % 2 == 0) begin : g_odd
				// first channel of the pair sits in the low nibble
				assign gain_w[g] = s_r.regs[int'(GAIN_PAIR1_IDX) + PAIR][ODD_GAIN_LSB +: 3];
				assign own_pwr_w[g] = s_r.regs[int'(GAIN_PAIR1_IDX) + PAIR][ODD_POWER_BIT];
			end else begin : g_even
				assign gain_w[g] = s_r.regs[int'(GAIN_PAIR1_IDX) + PAIR][EVEN_GAIN_LSB +: 3];
				assign own_pwr_w[g] = s_r.regs[int'(GAIN_PAIR1_IDX) + PAIR][EVEN_POWER_BIT];
			end
		end
	endgenerate

	// shorthand views of the live registers
	logic [7:0] mode_reg;
	logic [7:0] clk_reg;
	logic [7:0] pwr_reg;
	logic [7:0] in_reg;
	logic [7:0] pol_reg;
	assign mode_reg = s_r.regs[MODE_CONTROL_IDX];
	assign clk_reg = s_r.regs[CLOCK_DIVIDER_IDX];
	assign pwr_reg = s_r.regs[POWER_REFERENCE_IDX];
	assign in_reg = s_r.regs[INPUT_CONFIG_IDX];
	assign pol_reg = s_r.regs[POLARITY_CONFIG_IDX];

	// next-state logic
	always_comb begin
		logic [2:0] mlast;
		logic [2:0] smask;
		logic [10:0] dmask;
		logic tick;
		logic wr_ok;
		logic any_pwr;
		logic [N_CHAN-1:0] sel;
		logic [N_CHAN-1:0] inv_sel;
		mlast = mdiv_last(clk_reg[MDIV_LSB +: 3]);
		smask = sdiv_mask(clk_reg[SCLK_DIV_LSB +: 2]);
		dmask = dec_mask(clk_reg[DECIM_LSB +: 2]);
		tick = 1'b0;
		wr_ok = 1'b0;
		any_pwr = 1'b0;
		sel = in_reg[CHAN_SEL_LSB +: N_CHAN];
		inv_sel = pol_reg[CHAN_SEL_LSB +: N_CHAN];
		s_nxt = s_r;

		// master divider: one enable per divided period
		if (s_r.mdiv_cnt >= mlast) begin
			s_nxt.mdiv_cnt = 3'h0;
			tick = 1'b1;
		end else begin
			s_nxt.mdiv_cnt = s_r.mdiv_cnt + 3'h1;
		end
		s_nxt.divided_master_clock_en = tick;
		s_nxt.sclk_en = 1'b0;
		s_nxt.smp_en = 1'b0;

		case (s_r.st)
			// registers held at zero while the reset runs out
			ST_RESET: begin
				s_nxt.regs = '0;
				s_nxt.sdiv_cnt = 3'h0;
				s_nxt.dec_cnt = 11'h000;
				if (tick) begin
					if (s_r.rst_cnt <= 3'h1) begin
						s_nxt.st = ST_RUN;
						s_nxt.rst_cnt = 3'h0;
					end else begin
						s_nxt.rst_cnt = s_r.rst_cnt - 3'h1;
					end
				end
			end
			ST_RUN: begin
				// serial clock and sample strobes ride on the divided clock
				if (tick) begin
					s_nxt.sdiv_cnt = s_r.sdiv_cnt + 3'h1;
					s_nxt.dec_cnt = s_r.dec_cnt + 11'h001;
					s_nxt.sclk_en = (s_r.sdiv_cnt & smask) == smask;
					s_nxt.smp_en = (s_r.dec_cnt & dmask) == dmask;
				end
				// data mode locks the bank until a hardware reset
				wr_ok = reg_wr && (s_r.mode != MODE_DATA);
				if (wr_ok) begin
					s_nxt.regs[reg_wr_req.addr] = reg_wr_req.data;
					if (reg_wr_req.addr == MODE_CONTROL_IDX
						&& reg_wr_req.data[SOFT_RESET_BIT]) begin
						// soft reset wipes everything, itself included
						s_nxt.st = ST_RESET;
						s_nxt.rst_cnt = RESET_DIVIDED_MASTER_CLOCK_CYCLES;
						s_nxt.regs = '0;
					end
				end
			end
			default: begin
				s_nxt.st = ST_RESET;
				s_nxt.rst_cnt = RESET_DIVIDED_MASTER_CLOCK_CYCLES;
			end
		endcase

		// operating mode from the live mode register
		if (mode_reg[MIXED_MODE_BIT]) begin
			s_nxt.mode = MODE_MIXED;
		end else if (mode_reg[DATA_PROGRAM_BIT]) begin
			s_nxt.mode = MODE_DATA;
		end else begin
			s_nxt.mode = MODE_PROGRAM;
		end

		// channel controls
		for (int c = 0; c < N_CHAN; c++) begin
			s_nxt.chan[c].gain = gain_w[c];
			s_nxt.chan[c].powered = pwr_reg[GLOBAL_PU_BIT] | own_pwr_w[c];
			s_nxt.chan[c].mod_reset = in_reg[MOD_RESET_BIT] & sel[c];
			s_nxt.chan[c].single_ended = in_reg[SINGLE_ENDED_BIT] & sel[c];
			s_nxt.chan[c].inverted = pol_reg[FLIP_ENABLE_BIT] & inv_sel[c];
			any_pwr = any_pwr | s_nxt.chan[c].powered;
		end
		// reference can't drop while a channel needs it
		s_nxt.ref_pwr = pwr_reg[REF_POWER_BIT] | any_pwr;

		// read-back, registered
		s_nxt.rd_data = s_r.regs[reg_rd_addr];
	end

	// state register; hardware reset restarts the four-cycle reset
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s_r <= '0;
			s_r.st <= ST_RESET;
			s_r.rst_cnt <= RESET_DIVIDED_MASTER_CLOCK_CYCLES;
			s_r.regs <= {N_REGS{REG_RESET_VAL}};
			s_r.mode <= MODE_PROGRAM;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state word
	assign reg_rd_data = s_r.rd_data;
	assign op_mode = s_r.mode;
	assign cascade_count_field = mode_reg[CASCADE_LSB +: 3];
	assign control_echo = clk_reg[ECHO_BIT];
	assign port_loopback = mode_reg[LOOPBACK_BIT];
	assign test_mode_bit = pol_reg[TEST_MODE_BIT];
	assign reset_busy = (s_r.st == ST_RESET);
	assign divided_master_clock = s_r.divided_master_clock_en;
	assign serial_clock_en = s_r.sclk_en;
	assign sample_en = s_r.smp_en;
	assign chan_ctrl = s_r.chan;
	assign reference_power = s_r.ref_pwr;
	assign reference_output_pin = pwr_reg[REF_OUT_BIT];
	assign high_supply_mode = pwr_reg[HIGH_SUPPLY_BIT];
endmodule : afe_control_registers_clock_dividers
`default_nettype wire

/* tb/afe_ctrl_props.sv */
// port assertions for the control register bank
// assumes one ref_clk domain with synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module afe_ctrl_props
	import afe_ctrl_pkg::*;
(
	// watched ports
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic reg_wr,
	input wire reg_write_t reg_wr_req,
	input wire op_mode_t op_mode,
	input wire logic control_echo,
	input wire logic reset_busy,
	input wire logic serial_clock_en,
	input wire logic sample_en,
	input wire chan_ctrl_t [N_CHAN-1:0] chan_ctrl,
	input wire logic reference_power
);
	logic acc; // a write the bank takes
	logic [7:0] d1_r, d2_r; // write data one and two edges back
	logic [5:0] pw, se, mr, iv; // per-channel views
	assign acc = reg_wr && !reset_busy && op_mode != MODE_DATA;
	// flatten channel flags for whole-vector compares
	always_comb begin
		for (int i = 0; i < N_CHAN; i++) begin
			pw[i] = chan_ctrl[i].powered;
			se[i] = chan_ctrl[i].single_ended;
			mr[i] = chan_ctrl[i].mod_reset;
			iv[i] = chan_ctrl[i].inverted;
		end
	end
	// derived outputs land two edges after the write
	always_ff @(posedge ref_clk) begin
		d1_r <= reg_wr_req.data;
		d2_r <= d1_r;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	a_busy_after_reset: assert property ($fell(reset) |-> reset_busy[*3] ##[1:5] !reset_busy)
		else $error("reset busy window wrong");
	a_enables_quiet: assert property ($fell(reset) |-> !serial_clock_en && !sample_en)
		else $error("enable pulse during reset");
	a_mixed_mode: assert property (acc && reg_wr_req.addr == MODE_CONTROL_IDX && reg_wr_req.data[1] && !reg_wr_req.data[7] |=> ##1 op_mode == MODE_MIXED)
		else $error("mixed mode not entered");
	a_data_mode: assert property (acc && reg_wr_req.addr == MODE_CONTROL_IDX && reg_wr_req.data == 8'h01 |=> ##1 op_mode == MODE_DATA)
		else $error("data mode not entered");
	a_echo_bit: assert property (acc && reg_wr_req.addr == CLOCK_DIVIDER_IDX |=> control_echo == d1_r[ECHO_BIT])
		else $error("echo bit wrong");
	a_global_power: assert property (acc && reg_wr_req.addr == POWER_REFERENCE_IDX && reg_wr_req.data[0] |=> ##1 pw == 6'h3f && reference_power)
		else $error("global power-up ignored");
	a_soft_reset: assert property (acc && reg_wr_req.addr == MODE_CONTROL_IDX && reg_wr_req.data[7] |-> ##[1:2] reset_busy)
		else $error("soft reset not started");
	a_single_ended: assert property (acc && reg_wr_req.addr == INPUT_CONFIG_IDX |=> ##1 se == (d2_r[7] ? d2_r[5:0] : 6'h00))
		else $error("single-ended select wrong");
	a_mod_reset: assert property (acc && reg_wr_req.addr == INPUT_CONFIG_IDX |=> ##1 mr == (d2_r[6] ? d2_r[5:0] : 6'h00))
		else $error("modulator reset select wrong");
	a_invert_sel: assert property (acc && reg_wr_req.addr == POLARITY_CONFIG_IDX |=> ##1 iv == (d2_r[7] ? d2_r[5:0] : 6'h00))
		else $error("invert select wrong");
	c_write: cover property (acc);
	c_sample: cover property (sample_en);
	c_mixed: cover property (op_mode == MODE_MIXED);
endmodule : afe_ctrl_props
bind afe_control_registers_clock_dividers afe_ctrl_props u_props (.ref_clk, .reset, .reg_wr,
	.reg_wr_req, .op_mode, .control_echo, .reset_busy, .serial_clock_en, .sample_en, .chan_ctrl,
	.reference_power);
`default_nettype wire

/* tb/dsp_port_model.sv */
// serial-port stand-in handing decoded control words to the bank
// assumes the bench clock; one word per send call
`timescale 1ns/1ps
`default_nettype none
module dsp_port_model
	import afe_ctrl_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// decoded control word
	output logic reg_wr,
	output reg_write_t reg_wr_req
);
	initial begin
		reg_wr = 1'b0;
		reg_wr_req = '0;
	end
	// one-cycle pulse; word held whole until the taking edge
	task automatic send(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_wr_req <= '{addr: a, data: d};
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_wr_req.data <= ~d; // released data no longer shows the word
	endtask : send
endmodule : dsp_port_model
`default_nettype wire

/* tb/afe_control_registers_clock_dividers_test.sv */
// self-checking bench for the control register bank
// assumes the port stand-in writes; reads go through the read-back select
`timescale 1ns/1ps
`default_nettype none
module afe_control_registers_clock_dividers_test;
	import afe_ctrl_pkg::*;
	logic ref_clk = 1'b0;
	logic reset = 1'b1; // held ten cycles
	logic reg_wr;
	reg_write_t reg_wr_req;
	logic [2:0] reg_rd_addr = 3'h0;
	logic [7:0] reg_rd_data;
	op_mode_t op_mode;
	logic [2:0] cascade_count_field;
	logic control_echo, port_loopback, test_mode_bit, reset_busy;
	logic divided_master_clock, serial_clock_en, sample_en;
	chan_ctrl_t [N_CHAN-1:0] chan_ctrl;
	logic reference_power, reference_output_pin, high_supply_mode;
	logic [7:0] cfg [4] = '{8'hc5, 8'h05, 8'h8a, 8'h0a}; // input then polarity words
	int mismatches = 0;
	int total_checks = 0;
	int n;
	always #2.5 ref_clk = ~ref_clk;
	dsp_port_model u_dsp (.ref_clk, .reg_wr, .reg_wr_req);
	afe_control_registers_clock_dividers u_dut (.ref_clk, .reset, .reg_wr, .reg_wr_req,
		.reg_rd_addr, .reg_rd_data, .op_mode, .cascade_count_field, .control_echo,
		.port_loopback, .test_mode_bit, .reset_busy, .divided_master_clock, .serial_clock_en,
		.sample_en, .chan_ctrl, .reference_power, .reference_output_pin, .high_supply_mode);
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t: got %0h want %0h", $time, got, exp);
		end
	endtask : chk
	// write, then let derived outputs settle
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		u_dsp.send(a, d);
		repeat (2) @(posedge ref_clk);
		#1;
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_rd_addr <= a;
		repeat (2) @(posedge ref_clk);
		#1 chk(reg_rd_data, exp);
	endtask : rd
	// bounded wait for the reset window to close
	task automatic idle;
		for (int i = 0; i < 50 && reset_busy !== 1'b0; i++)
			@(posedge ref_clk);
		#1 chk(reset_busy, 1'b0);
	endtask : idle
	function automatic logic pick(input int s);
		return s == 0 ? divided_master_clock : s == 1 ? serial_clock_en : sample_en;
	endfunction : pick
	function automatic logic [5:0] fld(input int k);
		for (int i = 0; i < N_CHAN; i++)
			fld[i] = k == 0 ? chan_ctrl[i].single_ended : k == 1 ? chan_ctrl[i].mod_reset : chan_ctrl[i].inverted;
	endfunction : fld
	// pulse spacing; the first gaps after a change may be odd, so the third counts
	task automatic per(input int s, output int p);
		repeat (3) begin
			p = 0;
			do begin
				@(posedge ref_clk);
				#1 p++;
			end while (pick(s) !== 1'b1 && p < 5000);
		end
	endtask : per
	initial begin
		repeat (10) @(posedge ref_clk);
		reset <= 1'b0;
		idle();
		for (int i = 0; i < N_REGS; i++)
			rd(i[2:0], REG_RESET_VAL);
		chk(op_mode, MODE_PROGRAM);
		per(0, n);
		chk(n, 1);
		per(1, n);
		chk(n, 8);
		per(2, n);
		chk(n, 2048);
		$display("reset test done");
		for (int m = 0; m < 8; m++) begin
			wr(CLOCK_DIVIDER_IDX, {1'b0, m[2:0], m[1:0], 2'b11});
			per(0, n);
			chk(n, (m > 0 && m < 5) ? m + 1 : 1);
			per(1, n);
			chk(n, ((m > 0 && m < 5) ? m + 1 : 1) * (8 >> m[1:0]));
		end
		wr(CLOCK_DIVIDER_IDX, 8'h80);
		chk(control_echo, 1'b1);
		for (int r = 0; r < 4; r++) begin
			wr(CLOCK_DIVIDER_IDX, {6'h00, r[1:0]});
			per(2, n);
			chk(n, 2048 >> r);
		end
		$display("clock test done");
		wr(POWER_REFERENCE_IDX, 8'h01);
		for (int i = 0; i < N_CHAN; i++)
			chk(chan_ctrl[i].powered, 1'b1);
		wr(POWER_REFERENCE_IDX, 8'hc0);
		chk({reference_output_pin, high_supply_mode, reference_power, fld(3)}, 9'h180);
		for (int p = 0; p < 3; p++) begin
			logic [7:0] d;
			d = {p[0], 3'(p + 1), ~p[0], 3'(7 - p)};
			wr(GAIN_PAIR1_IDX + p[2:0], d);
			chk({chan_ctrl[2*p+1].gain, chan_ctrl[2*p].gain}, {d[6:4], d[2:0]});
			chk({chan_ctrl[2*p+1].powered, chan_ctrl[2*p].powered}, {d[7], d[3]});
			rd(GAIN_PAIR1_IDX + p[2:0], d);
		end
		chk(reference_power, 1'b1);
		for (int k = 0; k < 4; k++) begin
			wr(INPUT_CONFIG_IDX + k[2:1], cfg[k]);
			chk(fld(k[1] ? 2 : 0), cfg[k][7] ? cfg[k][5:0] : 6'h00);
			chk(fld(1), (cfg[k][6] && !k[1]) ? cfg[k][5:0] : 6'h00);
		end
		$display("channel test done");
		wr(MODE_CONTROL_IDX, 8'h32);
		chk({op_mode, cascade_count_field}, {MODE_MIXED, 3'h3});
		chk({port_loopback, test_mode_bit}, 2'b00);
		wr(MODE_CONTROL_IDX, 8'h03);
		chk(op_mode, MODE_MIXED);
		wr(MODE_CONTROL_IDX, 8'h80);
		chk(reset_busy, 1'b1);
		idle();
		rd(INPUT_CONFIG_IDX, 8'h00);
		wr(MODE_CONTROL_IDX, 8'h01);
		chk(op_mode, MODE_DATA);
		wr(POWER_REFERENCE_IDX, 8'h01);
		rd(POWER_REFERENCE_IDX, 8'h00);
		$display("mode test done");
		final_report();
	end
	// hang guard: about three times the expected run
	initial begin
		#300000;
		mismatches++;
		final_report();
	end
endmodule : afe_control_registers_clock_dividers_test
`default_nettype wire
